// >>> hw/flt_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "flt_regs_map.svh"

// Summary of operation
// - Mode code 00/11 auto, 01 bypass, 10 boost
// - Trip code selects 200 to 900 mV
// - Compare sense voltage to trip, flag trip
// - Torch ramp off at 000, else 16ms doubling
// - Bit7 modulation direction, bit6 strobe edge/level
// - Flash ramp 256us doubling to 32.768ms
// - Flash time-out 50 ms steps to 400
// - Torch total limit code, default 111
// - Flash total limit code, default 1111
// - Channel B gets maximum minus channel A
// - Maximum below A: A limited, B off
// - Channel A level code, 0x7F disables B
// - Level 0x00: A off, B full maximum
// - Strobe disabled: flash starts on flash_mode_sel alone
module flt_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Serial link pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Analog and pin side inputs
    input wire logic [11:0] temp_sense_mv,
    input wire logic flash_mode_sel,
    input wire logic strobe_pin,
    // Decoded configuration
    output flt_pkg::flt_boost_t boost_mode,
    output logic [9:0] trip_mv,
    output logic thermal_trip,
    output logic torch_ramp_en,
    output logic [10:0] torch_ramp_ms,
    output logic input_voltage_flash_monitor_updown,
    output logic strobe_edge,
    output logic [15:0] flash_ramp_us,
    output logic [8:0] flash_timeout_ms,
    output logic [2:0] torch_limit_code,
    output logic [3:0] flash_limit_code,
    output logic [6:0] channel_a_level,
    output logic [6:0] channel_b_level,
    output logic channel_b_on,
    output logic flash_go
);
    import flt_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Codes 00 and 11 both mean automatic operation.
    function automatic flt_boost_t boost_decode(input logic [1:0] code);
        case (code)
            2'h1: boost_decode = FLT_BOOST_BYPASS;
            2'h2: boost_decode = FLT_BOOST_FORCED;
            default: boost_decode = FLT_BOOST_AUTO;
        endcase
    endfunction

    // True when an offset lands on one of the four held registers.
    function automatic logic is_mapped(input logic [7:0] ofs);
        is_mapped = (ofs >= `FLT_OFS_THERMAL_RAMP) &&
                    (ofs <= `FLT_OFS_CHANNEL_A_FLASH);
    endfunction

    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------
    logic rst_q1;
    logic rst_n;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] stb_s;
    logic scl_f;
    logic sda_f;
    logic stb_f;

    // Reset is asserted at once but released only on a clock edge.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // Pins pass three flops; a level counts once stages two and three agree.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            stb_s <= 3'h0;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            stb_f <= 1'b0;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            stb_s <= {stb_s[1:0], strobe_pin};
            if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
            if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
            if (stb_s[1] == stb_s[2]) stb_f <= stb_s[2];
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic sda_rise;
    logic sda_fall;
    logic stb_rise;

    // Edges of the filtered levels.
    assign scl_rise = (scl_s[1] == scl_s[2]) && scl_s[2] && !scl_f;
    assign scl_fall = (scl_s[1] == scl_s[2]) && !scl_s[2] && scl_f;
    assign sda_rise = (sda_s[1] == sda_s[2]) && sda_s[2] && !sda_f;
    assign sda_fall = (sda_s[1] == sda_s[2]) && !sda_s[2] && sda_f;
    assign stb_rise = (stb_s[1] == stb_s[2]) && stb_s[2] && !stb_f;

    // ------------------------------------------------------------------
    // Serial slave and register file
    // ------------------------------------------------------------------
    flt_i2c_state_t state;
    flt_i2c_state_t next_state;
    flt_i2c_state_t ack_ret;
    flt_i2c_state_t next_ack_ret;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic is_read;
    logic next_is_read;
    logic next_sda_oe;
    logic [7:0] cfg [4];
    logic [7:0] next_cfg [4];
    logic [1:0] ptr_idx;

    assign ptr_idx = 2'(ptr - `FLT_OFS_THERMAL_RAMP);

    // A start or stop on the wire overrides any byte in progress, so a
    // host can always resynchronise a slave left mid-byte.
    always_comb begin
        next_state = state;
        next_ack_ret = ack_ret;
        next_shift = shift;
        next_cnt = cnt;
        next_ptr = ptr;
        next_is_read = is_read;
        next_sda_oe = sda_oe;
        next_cfg = cfg;
        if (sda_fall && scl_f && !scl_fall) begin
            next_state = FLT_ADDR;
            next_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (sda_rise && scl_f && !scl_fall) begin
            next_state = FLT_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                FLT_ADDR, FLT_REG, FLT_WDATA: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda_f};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == 4'h8) begin
                        next_state = FLT_ACK;
                        next_sda_oe = 1'b1;
                        if (state == FLT_ADDR) begin
                            next_is_read = shift[0];
                            next_ack_ret = shift[0] ? FLT_READ : FLT_REG;
                            next_shift = is_mapped(ptr) ? cfg[ptr_idx]
                                                        : `FLT_UNMAPPED_READ;
                            if (shift[7:1] != `FLT_DEV_ADDR) begin
                                next_state = FLT_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end else if (state == FLT_REG) begin
                            next_ptr = shift;
                            next_ack_ret = FLT_WDATA;
                        end else begin
                            if (is_mapped(ptr)) begin
                                next_cfg[ptr_idx] = shift;
                            end
                            next_ack_ret = FLT_WDATA;
                        end
                    end
                end
                FLT_ACK: begin
                    if (scl_fall) begin
                        next_state = ack_ret;
                        next_cnt = 4'h0;
                        next_sda_oe = 1'b0;
                        if (ack_ret == FLT_READ) begin
                            next_sda_oe = !shift[7];
                            next_shift = {shift[6:0], 1'b1};
                            next_cnt = 4'h1;
                        end
                    end
                end
                FLT_READ: begin
                    // Later falls put out the rest after the MSB.
                    if (scl_fall) begin
                        if (cnt == 4'h8) begin
                            next_state = FLT_MACK;
                            next_sda_oe = 1'b0;
                        end else begin
                            next_sda_oe = !shift[7];
                            next_shift = {shift[6:0], 1'b1};
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                FLT_MACK: begin
                    // One byte per read; the host's ack bit ends it.
                    if (scl_rise) next_state = FLT_IDLE;
                end
                default: begin
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FLT_IDLE;
            ack_ret <= FLT_IDLE;
            shift <= 8'h00;
            cnt <= 4'h0;
            ptr <= 8'h00;
            is_read <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            cfg[0] <= `FLT_RST_THERMAL_RAMP;
            cfg[1] <= `FLT_RST_FLASH_TIMING;
            cfg[2] <= `FLT_RST_CURRENT_LIMIT;
            cfg[3] <= `FLT_RST_CHANNEL_A_FLASH;
        end else begin
            state <= next_state;
            ack_ret <= next_ack_ret;
            shift <= next_shift;
            cnt <= next_cnt;
            ptr <= next_ptr;
            is_read <= next_is_read;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
            cfg <= next_cfg;
        end
    end

    // ------------------------------------------------------------------
    // Field decode and channel split
    // ------------------------------------------------------------------
    logic [7:0] r_tr;
    logic [7:0] r_ft;
    logic [7:0] r_cl;
    logic [7:0] r_ca;
    logic [2:0] tr_code;
    logic [2:0] fr_code;
    logic [2:0] to_code;
    logic [6:0] lvl_a;
    logic [6:0] max_a;
    logic [9:0] next_trip_mv;
    logic [6:0] next_a;
    logic [6:0] next_b;
    logic next_b_on;
    logic next_go;

    assign r_tr = cfg[0];
    assign r_ft = cfg[1];
    assign r_cl = cfg[2];
    assign r_ca = cfg[3];
    assign tr_code = r_tr[`FLT_TORCH_RAMP_MSB:`FLT_TORCH_RAMP_LSB];
    assign fr_code = r_ft[`FLT_FLASH_RAMP_MSB:`FLT_FLASH_RAMP_LSB];
    assign to_code = r_ft[`FLT_TIMEOUT_MSB:`FLT_TIMEOUT_LSB];
    assign lvl_a = r_ca[`FLT_LEVEL_A_MSB:`FLT_LEVEL_A_LSB];
    // A flash limit step is eight level steps, so limit code m equals
    // channel level 8m+7; both currents then compare in one unit.
    assign max_a = {r_cl[`FLT_FLASH_MAX_MSB:`FLT_FLASH_MAX_LSB], 3'h7};
    assign next_trip_mv = `FLT_TRIP_BASE_MV + 10'({7'h00,
        r_tr[`FLT_TRIP_MSB:`FLT_TRIP_LSB]}) * `FLT_TRIP_STEP_MV;

    // Channel sharing and flash start.
    always_comb begin
        next_a = lvl_a;
        next_b = 7'h00;
        next_b_on = 1'b0;
        if (lvl_a == 7'h00) begin
            next_b = max_a;
            next_b_on = 1'b1;
        end else if (max_a < lvl_a) begin
            next_a = max_a;
        end else begin
            next_b = max_a - lvl_a;
            next_b_on = (next_b != 7'h00);
        end
        if (!flash_mode_sel) begin
            next_go = 1'b0;
        end else if (!r_ca[`FLT_STROBE_EN_BIT]) begin
            next_go = 1'b1;
        end else if (r_ft[`FLT_STROBE_EDGE_BIT]) begin
            next_go = flash_go | stb_rise;
        end else begin
            next_go = stb_f;
        end
    end

    // Every decoded output is registered.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_mode <= FLT_BOOST_AUTO;
            trip_mv <= 10'h000;
            thermal_trip <= 1'b0;
            torch_ramp_en <= 1'b0;
            torch_ramp_ms <= 11'h000;
            input_voltage_flash_monitor_updown <= 1'b0;
            strobe_edge <= 1'b0;
            flash_ramp_us <= 16'h0000;
            flash_timeout_ms <= 9'h000;
            torch_limit_code <= 3'h0;
            flash_limit_code <= 4'h0;
            channel_a_level <= 7'h00;
            channel_b_level <= 7'h00;
            channel_b_on <= 1'b0;
            flash_go <= 1'b0;
        end else begin
            boost_mode <= boost_decode(r_tr[`FLT_BOOST_MSB:`FLT_BOOST_LSB]);
            trip_mv <= next_trip_mv;
            // The sense voltage falls as the thermistor heats.
            thermal_trip <= temp_sense_mv < {2'h0, next_trip_mv};
            torch_ramp_en <= (tr_code != 3'h0);
            torch_ramp_ms <= (tr_code == 3'h0) ? 11'h000 :
                `FLT_TORCH_RAMP_BASE_MS << (tr_code - 3'h1);
            input_voltage_flash_monitor_updown <=
                r_ft[`FLT_INPUT_VOLTAGE_FLASH_MONITOR_MOD_BIT];
            strobe_edge <= r_ft[`FLT_STROBE_EDGE_BIT];
            flash_ramp_us <= `FLT_FLASH_RAMP_BASE_US << fr_code;
            flash_timeout_ms <= 9'(({6'h00, to_code} + 9'h001) *
                `FLT_TIMEOUT_STEP_MS);
            torch_limit_code <=
                r_cl[`FLT_TORCH_MAX_MSB:`FLT_TORCH_MAX_LSB];
            flash_limit_code <=
                r_cl[`FLT_FLASH_MAX_MSB:`FLT_FLASH_MAX_LSB];
            channel_a_level <= next_a;
            channel_b_level <= next_b;
            channel_b_on <= next_b_on;
            flash_go <= next_go;
        end
    end

endmodule
`default_nettype wire

// >>> hw/flt_regs_map.svh
`ifndef FLT_REGS_MAP_SVH
`define FLT_REGS_MAP_SVH

// ----------------------------------------------------------------------
// Serial link addressing
// ----------------------------------------------------------------------
`define FLT_DEV_ADDR 7'h67
`define FLT_UNMAPPED_READ 8'hFF

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FLT_OFS_THERMAL_RAMP 8'h03
`define FLT_OFS_FLASH_TIMING 8'h04
`define FLT_OFS_CURRENT_LIMIT 8'h05
`define FLT_OFS_CHANNEL_A_FLASH 8'h06

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FLT_RST_THERMAL_RAMP 8'h20
`define FLT_RST_FLASH_TIMING 8'h42
`define FLT_RST_CURRENT_LIMIT 8'h7F
`define FLT_RST_CHANNEL_A_FLASH 8'h7F

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FLT_BOOST_MSB 7
`define FLT_BOOST_LSB 6
`define FLT_TRIP_MSB 5
`define FLT_TRIP_LSB 3
`define FLT_TORCH_RAMP_MSB 2
`define FLT_TORCH_RAMP_LSB 0
`define FLT_INPUT_VOLTAGE_FLASH_MONITOR_MOD_BIT 7
`define FLT_STROBE_EDGE_BIT 6
`define FLT_FLASH_RAMP_MSB 5
`define FLT_FLASH_RAMP_LSB 3
`define FLT_TIMEOUT_MSB 2
`define FLT_TIMEOUT_LSB 0
`define FLT_TORCH_MAX_MSB 6
`define FLT_TORCH_MAX_LSB 4
`define FLT_FLASH_MAX_MSB 3
`define FLT_FLASH_MAX_LSB 0
`define FLT_STROBE_EN_BIT 7
`define FLT_LEVEL_A_MSB 6
`define FLT_LEVEL_A_LSB 0

// ----------------------------------------------------------------------
// Thresholds and times in their own units
// ----------------------------------------------------------------------
`define FLT_TRIP_BASE_MV 10'h0C8
`define FLT_TRIP_STEP_MV 10'h064
`define FLT_TORCH_RAMP_BASE_MS 11'h010
`define FLT_FLASH_RAMP_BASE_US 16'h0100
`define FLT_TIMEOUT_STEP_MS 9'h032

`endif

// >>> hw/flt_pkg.sv
package flt_pkg;

    // Boost converter operating mode.
    typedef enum logic [1:0] {
        FLT_BOOST_AUTO,
        FLT_BOOST_BYPASS,
        FLT_BOOST_FORCED
    } flt_boost_t;

    // Serial slave sequencing.
    typedef enum logic [2:0] {
        FLT_IDLE,
        FLT_ADDR,
        FLT_REG,
        FLT_WDATA,
        FLT_ACK,
        FLT_READ,
        FLT_MACK
    } flt_i2c_state_t;

endpackage

// >>> test/flt_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module flt_regs_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Side inputs
    input wire logic [11:0] temp_sense_mv,
    input wire logic flash_mode_sel,
    // Decoded outputs
    input wire flt_pkg::flt_boost_t boost_mode,
    input wire logic [9:0] trip_mv,
    input wire logic thermal_trip,
    input wire logic torch_ramp_en,
    input wire logic [10:0] torch_ramp_ms,
    input wire logic [15:0] flash_ramp_us,
    input wire logic [8:0] flash_timeout_ms,
    input wire logic [3:0] flash_limit_code,
    input wire logic [6:0] channel_a_level,
    input wire logic [6:0] channel_b_level,
    input wire logic channel_b_on,
    input wire logic flash_go
);
    import flt_pkg::*;

    // ------------------------------------------------------------------
    // Decode checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Judged only while inputs sit still.
    property p_trip_cmp;
        $stable(temp_sense_mv) && $stable(trip_mv) ##1 $stable(trip_mv)
            |-> thermal_trip == ($past(temp_sense_mv) < trip_mv);
    endproperty
    a_trip_cmp: assert property (p_trip_cmp)
        else $error("thermal flag disagrees with threshold");

    // Zero shows only just after reset.
    property p_trip_range;
        trip_mv != 10'h000 |-> trip_mv >= 10'h0C8 && trip_mv <= 10'h384
            && trip_mv % 10'h064 == 10'h000;
    endproperty
    a_trip_range: assert property (p_trip_range)
        else $error("trip voltage off the ladder");

    property p_torch_ramp;
        torch_ramp_en == (torch_ramp_ms != 11'h000)
            && $onehot0(torch_ramp_ms) && torch_ramp_ms[3:0] == 4'h0;
    endproperty
    a_torch_ramp: assert property (p_torch_ramp)
        else $error("torch ramp time invalid");

    property p_flash_ramp;
        flash_ramp_us != 16'h0000
            |-> $onehot(flash_ramp_us) && flash_ramp_us[7:0] == 8'h00;
    endproperty
    a_flash_ramp: assert property (p_flash_ramp)
        else $error("flash ramp time invalid");

    property p_timeout;
        flash_timeout_ms != 9'h000 |-> flash_timeout_ms <= 9'h190
            && flash_timeout_ms % 9'h032 == 9'h000;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("flash time-out invalid");

    // The channels add up to the limit.
    property p_split;
        $stable(flash_limit_code) && $stable(channel_a_level)
            && flash_ramp_us != 16'h0000
            |-> {1'b0, channel_a_level} + {1'b0, channel_b_level}
            == {1'b0, flash_limit_code, 3'h7}
            && channel_b_on == (channel_b_level != 7'h00);
    endproperty
    a_split: assert property (p_split)
        else $error("channel split does not match limit");

    property p_go_off;
        !flash_mode_sel |=> !flash_go;
    endproperty
    a_go_off: assert property (p_go_off)
        else $error("flash active without flash mode");

    property p_boost;
        boost_mode != 2'h3;
    endproperty
    a_boost: assert property (p_boost)
        else $error("boost mode has no such value");

    c_trip: cover property ($rose(thermal_trip));
    c_go: cover property ($rose(flash_go));
    c_both: cover property (channel_b_on && channel_a_level != 7'h00);
endmodule

`default_nettype wire

// >>> test/flt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "flt_regs_map.svh"

module flt_host_model (
    // Clock
    input wire logic ref_clk,
    // Serial wires
    output logic scl,
    output logic sda_low,
    input wire logic sda_wire
);
    // Half period in cycles; the slave needs 4 or more.
    localparam int HALF = 22;

    // Idle bus: clock high and data released to the pull-up.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // One bit: data moves while the clock is low, read at end of high.
    task automatic bit_io(input logic b, output logic r);
        @(posedge ref_clk);
        sda_low <= ~b;
        repeat (HALF) @(posedge ref_clk);
        scl <= 1'b1;
        repeat (HALF) @(posedge ref_clk);
        r = sda_wire;
        scl <= 1'b0;
    endtask

    task automatic edge_cond(input logic stop);
        @(posedge ref_clk);
        sda_low <= 1'b1;
        repeat (HALF) @(posedge ref_clk);
        scl <= stop;
        repeat (HALF) @(posedge ref_clk);
        if (stop) begin
            sda_low <= 1'b0;
            repeat (HALF) @(posedge ref_clk);
        end
    endtask

    // Eight bits MSB first, then the ninth bit driven with m.
    task automatic byte_io(input logic [7:0] d, input logic m,
                           output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(m, r);
        ack = ~r;
    endtask

    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d,
                             output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        edge_cond(1'b0);
        byte_io({`FLT_DEV_ADDR, 1'b0}, 1'b1, q, a0);
        byte_io(ofs, 1'b1, q, a1);
        byte_io(d, 1'b1, q, a2);
        edge_cond(1'b1);
        ok = a0 & a1 & a2;
    endtask

    // Sets the pointer, then reads one byte.
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic [7:0] q;
        logic a;
        edge_cond(1'b0);
        byte_io({`FLT_DEV_ADDR, 1'b0}, 1'b1, q, a);
        byte_io(ofs, 1'b1, q, a);
        edge_cond(1'b1);
        edge_cond(1'b0);
        byte_io({`FLT_DEV_ADDR, 1'b1}, 1'b1, q, a);
        byte_io(8'hFF, 1'b0, d, a);
        edge_cond(1'b1);
    endtask
endmodule

`default_nettype wire

// >>> test/flt_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module flt_regs_tb_top;
    import flt_pkg::*;

    logic ref_clk, resetn, scl, host_low, sda_out, sda_oe, sda_wire;
    logic flash_mode_sel, strobe_pin, thermal_trip, torch_ramp_en;
    logic input_voltage_flash_monitor_updown, strobe_edge, channel_b_on;
    logic flash_go;
    logic [11:0] temp_sense_mv;
    logic [9:0] trip_mv;
    logic [10:0] torch_ramp_ms;
    logic [15:0] flash_ramp_us;
    logic [8:0] flash_timeout_ms;
    logic [2:0] torch_limit_code;
    logic [3:0] flash_limit_code;
    logic [6:0] channel_a_level, channel_b_level;
    logic [13:0] e;
    flt_boost_t boost_mode;
    int err_count, comparisons, cycles;
    logic [7:0] dflt [4] = '{8'h20, 8'h42, 8'h7F, 8'h7F};
    logic [15:0] cur [4] = '{16'h7500, 16'h3340, 16'h0A10, 16'h7F7F};

    // Open-drain data line with its pull-up.
    assign sda_wire = ~(host_low | (sda_oe & ~sda_out));

    flt_regs i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .temp_sense_mv(temp_sense_mv), .flash_mode_sel(flash_mode_sel),
        .strobe_pin(strobe_pin), .boost_mode(boost_mode),
        .trip_mv(trip_mv), .thermal_trip(thermal_trip),
        .torch_ramp_en(torch_ramp_en), .torch_ramp_ms(torch_ramp_ms),
        .input_voltage_flash_monitor_updown(
            input_voltage_flash_monitor_updown),
        .strobe_edge(strobe_edge), .flash_ramp_us(flash_ramp_us),
        .flash_timeout_ms(flash_timeout_ms),
        .torch_limit_code(torch_limit_code),
        .flash_limit_code(flash_limit_code),
        .channel_a_level(channel_a_level),
        .channel_b_level(channel_b_level),
        .channel_b_on(channel_b_on), .flash_go(flash_go)
    );

    flt_host_model i_host (
        .ref_clk(ref_clk), .scl(scl), .sda_low(host_low),
        .sda_wire(sda_wire)
    );

    // ------------------------------------------------------------------
    // Clock, watchdog and reporting
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // The sequence needs about 49k cycles; a hang is cut at 90k.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("mismatches %0d compares %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        logic ok;
        i_host.write_reg(o, d, ok);
        check(ok, 1'b1);
    endtask

    task automatic rd(input logic [7:0] o, input logic [7:0] exp);
        logic [7:0] d;
        i_host.read_reg(o, d);
        check(d, exp);
    endtask

    // Expected levels of both channels.
    function automatic logic [13:0] split(input logic [3:0] m,
                                          input logic [6:0] a);
        logic [6:0] l;
        l = {m, 3'h7};
        if (a == 7'h00) return {7'h00, l};
        if (a > l) return {l, 7'h00};
        return {a, l - a};
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        temp_sense_mv = 12'h000;
        flash_mode_sel = 1'b0;
        strobe_pin = 1'b0;
        err_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check(boost_mode, FLT_BOOST_AUTO);
        check(trip_mv, 10'h258);
        check({torch_ramp_en, torch_ramp_ms}, 12'h000);
        check({input_voltage_flash_monitor_updown, strobe_edge}, 2'h1);
        check(flash_ramp_us, 16'h0100);
        check(flash_timeout_ms, 9'h096);
        check({torch_limit_code, flash_limit_code}, 7'h7F);
        check({channel_a_level, channel_b_on}, 8'hFE);
        for (int i = 0; i < 4; i++) rd(8'h03 + i[7:0], dflt[i]);
        // Every code of both timing registers.
        for (int c = 0; c < 8; c++) begin
            wr(8'h03, {c[1:0], c[2:0], c[2:0]});
            wr(8'h04, {c[0], c[1], c[2:0], c[2:0]});
            check(boost_mode, c[1:0] == 2'h1 ? FLT_BOOST_BYPASS :
                c[1:0] == 2'h2 ? FLT_BOOST_FORCED : FLT_BOOST_AUTO);
            check(trip_mv, 10'h0C8 + 10'h064 * c[2:0]);
            check({torch_ramp_en, torch_ramp_ms},
                c == 0 ? 12'h000 : {1'b1, 11'h008 << c});
            check({input_voltage_flash_monitor_updown, strobe_edge},
                {c[0], c[1]});
            check(flash_ramp_us, 16'h0100 << c);
            check(flash_timeout_ms, 16'h0032 * (c + 1));
            temp_sense_mv <= 12'h0C7 + 12'h064 * c[2:0];
            repeat (3) @(posedge ref_clk);
            check(thermal_trip, 1'b1);
            temp_sense_mv <= 12'h0C8 + 12'h064 * c[2:0];
            repeat (3) @(posedge ref_clk);
            check(thermal_trip, 1'b0);
        end
        // Sharing between the channels.
        for (int i = 0; i < 4; i++) begin
            wr(8'h05, cur[i][15:8]);
            wr(8'h06, cur[i][7:0]);
            e = split(cur[i][11:8], cur[i][6:0]);
            check({torch_limit_code, flash_limit_code}, cur[i][14:8]);
            check({e, e[6:0] != 7'h00},
                {channel_a_level, channel_b_level, channel_b_on});
        end
        // Strobe disabled: flash starts with the mode alone.
        flash_mode_sel <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(flash_go, 1'b1);
        flash_mode_sel <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(flash_go, 1'b0);
        // Edge mode: a strobe rise starts and latches.
        wr(8'h06, 8'hFF);
        flash_mode_sel <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check(flash_go, 1'b0);
        strobe_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        strobe_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check(flash_go, 1'b1);
        // Level mode follows the strobe.
        wr(8'h04, 8'h00);
        check(flash_go, 1'b0);
        strobe_pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check(flash_go, 1'b1);
        flash_mode_sel <= 1'b0;
        // Unmapped offset is accepted but holds nothing.
        wr(8'h07, 8'h00);
        rd(8'h07, 8'hFF);
        rd(8'h06, 8'hFF);
        rd(8'h05, 8'h7F);
        report_and_stop();
    end
endmodule

bind flt_regs flt_regs_assertions i_chk (
    .ref_clk(ref_clk), .resetn(resetn), .temp_sense_mv(temp_sense_mv),
    .flash_mode_sel(flash_mode_sel), .boost_mode(boost_mode),
    .trip_mv(trip_mv), .thermal_trip(thermal_trip),
    .torch_ramp_en(torch_ramp_en), .torch_ramp_ms(torch_ramp_ms),
    .flash_ramp_us(flash_ramp_us), .flash_timeout_ms(flash_timeout_ms),
    .flash_limit_code(flash_limit_code),
    .channel_a_level(channel_a_level), .channel_b_level(channel_b_level),
    .channel_b_on(channel_b_on), .flash_go(flash_go)
);

`default_nettype wire
